// *** supervisor_timeout_watchdog_pkg.sv ***
// Constants, types and register map of the supervisor timeout watchdog
// Contract
// - Reset output asserts on undervoltage or while manual reset is low.
// - Manual reset low keeps reset asserted for as long as it stays low.
// - Without a separate fault pin, a watchdog timeout asserts the reset.
// - Watchdog monitors only while the enable input is high.
// - Two select inputs and enable choose timeout scale and on or off.
// - Fault output asserts on watchdog error, only while reset is high.
// - Fault output stays asserted exactly the reset delay, then releases.
// - While reset is asserted, fault is released and monitoring stops.
// - Latched mode holds the output until the fault is cleared.
package supervisor_timeout_watchdog_pkg;

  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Times in milliseconds and the derived cycle counts
  localparam int WD_TIMEOUT_MS = 100;
  localparam int RESET_DELAY_MS = 200;
  localparam logic [31:0] WD_TIMEOUT_CYC = 32'(WD_TIMEOUT_MS * CLK_MHZ * 1000);
  localparam logic [31:0] RESET_DELAY_CYC =
    32'(RESET_DELAY_MS * CLK_MHZ * 1000);

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] MASK_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] STATE_OFS = 12'h00C;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 12'h010;

  // Control fields
  localparam int CTRL_SEP_FAULT_BIT = 0;
  localparam int CTRL_LATCH_BIT = 1;
  localparam int CTRL_CLEAR_BIT = 2;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h1;

  // Event fields, shared by status and mask
  localparam int EV_WD_BIT = 0;
  localparam int EV_UV_BIT = 1;
  localparam int EV_MAN_BIT = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;

  // Synchroniser lanes
  localparam int PIN_UV = 0;
  localparam int PIN_MAN = 1;
  localparam int PIN_KICK = 2;
  localparam int PIN_EN = 3;
  localparam int PIN_SEL_LO = 4;
  localparam int PIN_SEL_HI = 5;
  localparam int PIN_W = 6;
  localparam logic [PIN_W-1:0] PIN_RST = 6'h02;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_DELAY,
    ST_WD_RST,
    ST_WD_FLT,
    ST_LATCH_RST,
    ST_LATCH_FLT
  } state_t;

endpackage : supervisor_timeout_watchdog_pkg

// *** supervisor_timeout_watchdog.sv ***
// Supply supervisor with timeout watchdog and APB register access
`timescale 1ns/1ps
`default_nettype none
module supervisor_timeout_watchdog #(
  parameter logic [31:0] WD_BASE_CYC =
    supervisor_timeout_watchdog_pkg::WD_TIMEOUT_CYC,
  parameter logic [31:0] RST_DLY_CYC =
    supervisor_timeout_watchdog_pkg::RESET_DELAY_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [supervisor_timeout_watchdog_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [supervisor_timeout_watchdog_pkg::DATA_W-1:0] pwdata_in,
  output logic [supervisor_timeout_watchdog_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic undervoltage_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_enable_in,
  input wire logic timing_select_lo_in,
  input wire logic timing_select_hi_in,
  output logic reset_n_out,
  output logic watchdog_fault_n_out,
  output logic irq_out
);
  import supervisor_timeout_watchdog_pkg::*;

  // Pin synchronisers
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync1_ff;
  logic [PIN_W-1:0] sync2_ff;

  assign pins_raw = {timing_select_hi_in, timing_select_lo_in,
                     watchdog_enable_in, watchdog_kick_in,
                     manual_reset_n_in, undervoltage_in};

  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        sync1_ff[i] <= PIN_RST[i];
        sync2_ff[i] <= PIN_RST[i];
      end else begin
        sync1_ff[i] <= pins_raw[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  logic uv_s;
  logic man_s;
  logic kick_s;
  logic en_s;
  logic [1:0] sel_s;
  logic cause;

  assign uv_s = sync2_ff[PIN_UV];
  assign man_s = sync2_ff[PIN_MAN];
  assign kick_s = sync2_ff[PIN_KICK];
  assign en_s = sync2_ff[PIN_EN];
  assign sel_s = {sync2_ff[PIN_SEL_HI], sync2_ff[PIN_SEL_LO]};
  assign cause = uv_s | ~man_s;

  // Edge history
  logic kick_prev_ff;
  logic uv_prev_ff;
  logic man_prev_ff;
  logic kick_fall;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      kick_prev_ff <= 1'b0;
      uv_prev_ff <= 1'b0;
      man_prev_ff <= 1'b1;
    end else begin
      kick_prev_ff <= kick_s;
      uv_prev_ff <= uv_s;
      man_prev_ff <= man_s;
    end
  end

  assign kick_fall = kick_prev_ff & ~kick_s;

  // APB decode and software-held state
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic [EV_W-1:0] status_ff;
  logic [EV_W-1:0] nxt_status;
  logic [EV_W-1:0] mask_ff;
  logic [EV_W-1:0] nxt_mask;
  logic [DATA_W-1:0] prdata_ff;
  logic [DATA_W-1:0] nxt_prdata;
  logic [EV_W-1:0] events;
  logic addr_ok;
  logic wr_en;
  logic latch_clr;
  logic sep_fault;
  logic latch_on;

  assign addr_ok = (paddr_in == CTRL_OFS) || (paddr_in == STATUS_OFS) ||
                   (paddr_in == MASK_OFS) || (paddr_in == STATE_OFS) ||
                   (paddr_in == COUNT_OFS);
  assign wr_en = psel_in & penable_in & pwrite_in & addr_ok;
  assign latch_clr = wr_en & (paddr_in == CTRL_OFS) &
                     pwdata_in[CTRL_CLEAR_BIT];
  assign sep_fault = ctrl_ff[CTRL_SEP_FAULT_BIT];
  assign latch_on = ctrl_ff[CTRL_LATCH_BIT];
  // Zero-wait slave: read data is captured in the setup cycle
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  // Watchdog and output sequencing
  state_t state_ff;
  state_t nxt_state;
  logic [31:0] dly_cnt_ff;
  logic [31:0] nxt_dly_cnt;
  logic [31:0] wd_cnt_ff;
  logic [31:0] nxt_wd_cnt;
  logic [31:0] wd_limit;
  logic reset_n_ff;
  logic nxt_reset_n;
  logic fault_n_ff;
  logic nxt_fault_n;
  logic monitoring;
  logic wd_expire;

  // Scale 1x, 2x, 4x or 8x of the base timeout
  assign wd_limit = WD_BASE_CYC << sel_s;
  // Monitoring stops in every asserted state and as soon as a cause shows
  assign monitoring = en_s & ~cause & (state_ff == ST_IDLE);
  assign wd_expire = monitoring & ~kick_fall &
                     (wd_cnt_ff == wd_limit - 32'h0000_0001);

  always_comb begin
    nxt_wd_cnt = wd_cnt_ff + 32'h0000_0001;
    if (!monitoring || kick_fall || wd_expire) begin
      nxt_wd_cnt = 32'h0000_0000;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_dly_cnt = 32'h0000_0000;
    if (cause) begin
      nxt_state = ST_HOLD;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (wd_expire) begin
            if (sep_fault) begin
              nxt_state = latch_on ? ST_LATCH_FLT : ST_WD_FLT;
            end else begin
              nxt_state = latch_on ? ST_LATCH_RST : ST_WD_RST;
            end
          end
        end
        ST_HOLD: begin
          nxt_state = latch_on ? ST_LATCH_RST : ST_DELAY;
        end
        ST_DELAY, ST_WD_RST, ST_WD_FLT: begin
          nxt_dly_cnt = dly_cnt_ff + 32'h0000_0001;
          if (dly_cnt_ff == RST_DLY_CYC - 32'h0000_0001) begin
            nxt_state = ST_IDLE;
            nxt_dly_cnt = 32'h0000_0000;
          end
        end
        ST_LATCH_RST, ST_LATCH_FLT: begin
          if (latch_clr) begin
            nxt_state = ST_IDLE;
          end
        end
        default: begin
          nxt_state = ST_HOLD;
        end
      endcase
    end
    // Both outputs drive low when asserted
    nxt_reset_n = !((nxt_state == ST_HOLD) || (nxt_state == ST_DELAY) ||
                    (nxt_state == ST_WD_RST) ||
                    (nxt_state == ST_LATCH_RST));
    nxt_fault_n = !((nxt_state == ST_WD_FLT) ||
                    (nxt_state == ST_LATCH_FLT));
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_DELAY;
      dly_cnt_ff <= 32'h0000_0000;
      wd_cnt_ff <= 32'h0000_0000;
      reset_n_ff <= 1'b0;
      fault_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      dly_cnt_ff <= nxt_dly_cnt;
      wd_cnt_ff <= nxt_wd_cnt;
      reset_n_ff <= nxt_reset_n;
      fault_n_ff <= nxt_fault_n;
    end
  end

  assign reset_n_out = reset_n_ff;
  assign watchdog_fault_n_out = fault_n_ff;

  // Register file next values
  always_comb begin
    events = EV_RST;
    events[EV_WD_BIT] = wd_expire;
    events[EV_UV_BIT] = uv_s & ~uv_prev_ff;
    events[EV_MAN_BIT] = man_prev_ff & ~man_s;
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    if (wr_en && paddr_in == CTRL_OFS) begin
      nxt_ctrl = pwdata_in[CTRL_W-1:0];
    end
    if (wr_en && paddr_in == MASK_OFS) begin
      nxt_mask = pwdata_in[EV_W-1:0];
    end
    if (wr_en && paddr_in == STATUS_OFS) begin
      nxt_status = status_ff & ~pwdata_in[EV_W-1:0];
    end
    // A new event beats a clear in the same cycle
    nxt_status = nxt_status | events;
    nxt_prdata = prdata_ff;
    if (psel_in && !penable_in) begin
      nxt_prdata = 32'h0000_0000;
      case (paddr_in)
        CTRL_OFS: nxt_prdata[CTRL_W-1:0] = ctrl_ff;
        STATUS_OFS: nxt_prdata[EV_W-1:0] = status_ff;
        MASK_OFS: nxt_prdata[EV_W-1:0] = mask_ff;
        STATE_OFS: nxt_prdata[3:0] = {(state_ff == ST_LATCH_RST) ||
                                      (state_ff == ST_LATCH_FLT),
                                      monitoring, fault_n_ff, reset_n_ff};
        COUNT_OFS: nxt_prdata = wd_cnt_ff;
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_ff <= CTRL_RST;
      status_ff <= EV_RST;
      mask_ff <= EV_RST;
      prdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata_out = prdata_ff;
  assign irq_out = |(status_ff & mask_ff);

  // Helper: cycles the fault output has been low
  logic [31:0] flt_len_ff;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flt_len_ff <= 32'h0000_0000;
    end else begin
      flt_len_ff <= fault_n_ff ? 32'h0000_0000 : flt_len_ff + 32'h0000_0001;
    end
  end

  a_cause_resets: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    uv_s |=> !reset_n_out) else $error("undervoltage did not reset");

  a_manual_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!man_s ##1 !man_s) |-> !reset_n_out ##1 !reset_n_out)
    else $error("manual reset not held");

  a_wd_to_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wd_expire && !sep_fault |=> !reset_n_out && watchdog_fault_n_out)
    else $error("timeout did not reset");

  a_enable_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !en_s |=> wd_cnt_ff == 32'h0000_0000 && !wd_expire)
    else $error("watchdog ran while disabled");

  a_count_steps: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    monitoring && !kick_fall && !wd_expire |=>
    wd_cnt_ff == $past(wd_cnt_ff) + 32'h0000_0001)
    else $error("watchdog count stalled");

  a_fault_reset_hi: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !watchdog_fault_n_out |-> reset_n_out)
    else $error("fault asserted during reset");

  a_fault_width: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(watchdog_fault_n_out) && $past(state_ff) == ST_WD_FLT &&
    state_ff == ST_IDLE |-> flt_len_ff == RST_DLY_CYC)
    else $error("fault pulse width wrong");

  a_reset_suspends: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !reset_n_out |-> watchdog_fault_n_out && wd_cnt_ff == 32'h0000_0000)
    else $error("monitoring during reset");

  a_latch_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_ff == ST_LATCH_FLT && !latch_clr && !cause |=>
    !watchdog_fault_n_out) else $error("latched fault released");

  a_kick_restarts: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    kick_fall |=> wd_cnt_ff == 32'h0000_0000 && !$past(wd_expire))
    else $error("kick did not restart");

  a_expire_full: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wd_expire |-> wd_cnt_ff == wd_limit - 32'h0000_0001 && !kick_fall)
    else $error("early watchdog error");

  a_active_low: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_ff == ST_HOLD |-> !reset_n_out)
    else $error("reset not driven low");

  a_irq_level: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wd_expire && mask_ff[EV_WD_BIT] |=> irq_out)
    else $error("interrupt missing");

  c_wd_fault: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wd_expire && sep_fault ##1 !watchdog_fault_n_out);
  c_wd_reset: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wd_expire && !sep_fault ##1 !reset_n_out);
  c_latch_clear: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (state_ff == ST_LATCH_FLT) && latch_clr);
  c_manual: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $fell(man_s) ##1 !reset_n_out);

endmodule : supervisor_timeout_watchdog
`default_nettype wire

// *** host_kick_model.sv ***
// Host microcontroller model that services the watchdog by kick pulses
`timescale 1ns/1ps
`default_nettype none
module host_kick_model (
  input wire logic clk_in,
  input wire logic active_in,
  input wire logic [7:0] period_in,
  input wire logic reset_n_in,
  output logic kick_out
);
  logic [7:0] cnt;

  initial begin
    cnt = 8'h00;
    kick_out = 1'b0;
  end

  // A host held in reset cannot service the watchdog
  always @(posedge clk_in) begin
    if (!active_in || !reset_n_in) begin
      cnt <= 8'h00;
      kick_out <= 1'b0;
    end else begin
      cnt <= (cnt + 8'h01 >= period_in) ? 8'h00 : cnt + 8'h01;
      // Two cycles high so the synchroniser cannot miss the fall
      kick_out <= (cnt < 8'h02);
    end
  end
endmodule : host_kick_model
`default_nettype wire

// *** supervisor_timeout_watchdog_test.sv ***
// Self-checking testbench of the supervisor timeout watchdog
`timescale 1ns/1ps
`default_nettype none
module supervisor_timeout_watchdog_test;
  import supervisor_timeout_watchdog_pkg::*;
  // Shortened counts keep the run small
  localparam int B = 20;
  localparam int D = 10;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err, uv = 1'b0, man_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic kick, en = 1'b0, s_lo = 1'b0, s_hi = 1'b0, host_on = 1'b0;
  logic rst_n, fault_n, irq;
  logic [7:0] period = 8'h0f;
  int n_mismatch = 0, compares = 0, cyc = 0, n;

  always #5 clk = ~clk;

  supervisor_timeout_watchdog #(.WD_BASE_CYC(32'(B)), .RST_DLY_CYC(32'(D)))
  i_supervisor_timeout_watchdog (
    .sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .undervoltage_in(uv),
    .manual_reset_n_in(man_n), .watchdog_kick_in(kick),
    .watchdog_enable_in(en), .timing_select_lo_in(s_lo),
    .timing_select_hi_in(s_hi), .reset_n_out(rst_n),
    .watchdog_fault_n_out(fault_n), .irq_out(irq));

  host_kick_model i_host_kick_model (
    .clk_in(clk), .active_in(host_on), .period_in(period),
    .reset_n_in(rst_n), .kick_out(kick));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask : idle

  task automatic wait_low(input bit f);
    n = 0;
    while ((f ? fault_n : rst_n) !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_low

  task automatic len_low(input bit f);
    n = 0;
    while ((f ? fault_n : rst_n) === 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask : len_low

  task automatic fault_free(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      if (fault_n !== 1'b1 || rst_n !== 1'b1) n++;
    end
  endtask : fault_free

  task automatic finish_test();
    $display("Counts: %0d mismatches, %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Ceiling well above the fewer than two thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(13230));
    idle(3);
    chk(rst_n, 0);
    chk(fault_n, 1);
    rst_b <= 1'b1;
    idle(D + 8);
    chk(rst_n, 1);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'(CTRL_RST));
    apb(1'b0, MASK_OFS, 32'h0000_0000);
    chk(rd, 0);
    chk(32'(pready), 1);
    apb(1'b0, STATE_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b0, COUNT_OFS, 32'h0000_0000);
    chk(rd, 0);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(rd, 0);
    chk(32'(err), 1);
    apb(1'b1, MASK_OFS, 32'h0000_0007);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      if (i == 0) man_n <= 1'b0;
      else uv <= 1'b1;
      idle(5 + $urandom % 16);
      chk(rst_n, 0);
      man_n <= 1'b1;
      uv <= 1'b0;
      idle(D - 2);
      chk(rst_n, 0);
      idle(8);
      chk(rst_n, 1);
      chk(irq, 1);
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0001 << (i ? EV_UV_BIT : EV_MAN_BIT));
      apb(1'b1, STATUS_OFS, 32'h0000_0007);
      chk(irq, 0);
      $display("test cause %0d done", i);
    end
    {s_hi, s_lo} <= 2'($urandom % 4);
    period <= 8'(5 + $urandom % 10);
    host_on <= 1'b1;
    en <= 1'b1;
    fault_free(400);
    chk(n, 0);
    host_on <= 1'b0;
    en <= 1'b0;
    fault_free(300);
    chk(n, 0);
    $display("test service done");
    for (int s = 0; s < 4; s++) begin
      {s_hi, s_lo} <= 2'(s);
      en <= 1'b1;
      wait_low(1'b1);
      chk(n >= (B << s) && n <= (B << s) + 6, 1);
      chk(rst_n, 1);
      len_low(1'b1);
      chk(n, D);
      en <= 1'b0;
      idle(3);
    end
    chk(irq, 1);
    apb(1'b1, STATUS_OFS, 32'h0000_0001);
    chk(irq, 0);
    $display("test timeout scale done");
    en <= 1'b1;
    wait_low(1'b1);
    chk(fault_n, 0);
    man_n <= 1'b0;
    idle(5);
    chk(fault_n, 1);
    chk(rst_n, 0);
    man_n <= 1'b1;
    en <= 1'b0;
    idle(D + 8);
    $display("test pre-empt done");
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    en <= 1'b1;
    wait_low(1'b0);
    chk(fault_n, 1);
    len_low(1'b0);
    chk(n, D);
    en <= 1'b0;
    idle(3);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    en <= 1'b1;
    wait_low(1'b1);
    en <= 1'b0;
    idle(3 * D);
    chk(fault_n, 0);
    apb(1'b0, STATE_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0009);
    apb(1'b1, CTRL_OFS, 32'h0000_0007);
    idle(3);
    chk(fault_n, 1);
    $display("test variants done");
    finish_test();
  end
endmodule : supervisor_timeout_watchdog_test
`default_nettype wire
